// file: chan_xing_pkg.sv
/*
 Package for the per-channel clock-crossing configuration bank.
 Assumes dword configuration accesses addressed by byte offset.
*/
package chan_xing_pkg;
	localparam int num_channels = 3;
	localparam logic [7:0] off_rx_crossing = 8'hC8;
	localparam logic [7:0] off_ew_ratio = 8'hCC;
	localparam logic [7:0] off_ew_offsets = 8'hD0;
	localparam logic [7:0] off_read_latency = 8'hD4;
	localparam logic [7:0] off_page_close = 8'hD8;
	localparam logic [7:0] off_tx_ratios = 8'hE0;
	localparam logic [7:0] off_tx_cmd_offsets = 8'hE4;
	localparam logic [7:0] off_tx_data_offsets = 8'hE8;
	// Field positions (low bit)
	localparam int pos_ptr_sep = 24;
	localparam int pos_offset = 16;
	localparam int pos_far = 8;
	localparam int pos_home = 0;
	localparam int pos_rd_ptr = 14;
	localparam int pos_wr_ptr = 10;
	localparam int pos_fifo_ptr = 8;
	// Reset values
	localparam logic [2:0] rst_ptr_sep = 3'h2;
	localparam logic [7:0] rst_rx_offset = 8'h00;
	localparam logic [7:0] rst_rx_far = 8'h01;
	localparam logic [7:0] rst_rx_home = 8'h02;
	localparam logic [7:0] rst_ew_far = 8'h01;
	localparam logic [7:0] rst_ew_even = 8'h02;
	localparam logic [7:0] rst_ew_odd = 8'h00;
	localparam logic [7:0] rst_latency = 8'h00;
	localparam logic [15:0] rst_page_close = 16'h0000;
	localparam logic [7:0] rst_tx_far = 8'h01;
	localparam logic [7:0] rst_tx_home = 8'h04;
	localparam logic [9:0] rst_cmd_offsets = 10'h000;
	localparam logic [16:0] rst_data_offsets = 17'h00000;
	localparam logic [3:0] page_count_low_bits = 4'h0;
endpackage

// file: chan_xing_cfg.sv
/*
 Three channel copies of the clock-crossing configuration registers with
 the derived gearing outputs and a page-close interval timer per channel.
 Assumes a dword config port: cfg_wr/cfg_rd strobes, channel select and
 byte offset, one access per cycle from logic on ref_clk.
*/
// Contract
// - Pointer separation field stored and read back, never used by hardware.
// - Receive pointer separation derives from round-trip latency, growing with it.
// - Round-trip latency is eight bits in uncore cycles, read CAS to data.
// - Timeout field gives top eight bits of twelve; upper byte reserved zero; the bank stores and reads back bits 15:8 as written.
// - Twelve-bit count sets page-close flag interval; larger means less aggressive.
// - Command FIFOs of all channels use channel 0 command offsets.
// - Receive register: offset 23:16, far ratio 15:8, home ratio 7:0.
// - Early-warning far ratio in bits 15:8, reset one.
// - Early-warning even offset 15:8 reset two, odd offset 7:0 reset zero.
// - Transmit far ratio 15:8 reset one, home ratio 7:0 reset four.
// - Command offsets: pointer shift 9:8, bubble shift 7:0, reset zero.
// - Data offsets: read 16:14, write 13:10, pointer 9:8, bubble 7:0.
module chan_xing_cfg
	import chan_xing_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [1:0] cfg_chan,
	input wire logic [7:0] cfg_offset,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	output logic [23:0] rx_gearing,
	output logic [23:0] rx_pointer_separation,
	output logic [23:0] warning_far_ratio,
	output logic [23:0] warning_even_phase_offset,
	output logic [23:0] warning_odd_phase_offset,
	output logic [23:0] tx_far_ratio,
	output logic [23:0] tx_home_ratio,
	output logic [5:0] cmd_fifo_pointer_shift,
	output logic [23:0] cmd_bubble_gen_shift,
	output logic [50:0] data_fifo_offsets,
	output logic [2:0] page_close_flag
);
	import chan_xing_pkg::*;

	logic [31:0] rd_mux [num_channels];
	logic [31:0] rdata_nxt;
	logic [31:0] rdata_r;
	logic rvalid_r;

	assign rdata_nxt = (cfg_chan < 2'(num_channels)) ?
		rd_mux[cfg_chan] : 32'h0000_0000;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= cfg_rd ? rdata_nxt : rdata_r;
			rvalid_r <= cfg_rd;
		end
	end
	assign cfg_rdata = rdata_r;
	assign cfg_rvalid = rvalid_r;

	logic [7:0] cmd_bg0;
	logic [1:0] cmd_ptr0;

	// Offset decode, shared by the three channel copies
	logic hit_rx;
	logic hit_ew_ratio;
	logic hit_ew_offsets;
	logic hit_latency;
	logic hit_page;
	logic hit_tx_ratios;
	logic hit_cmd;
	logic hit_data;

	assign hit_rx = (cfg_offset == off_rx_crossing);
	assign hit_ew_ratio = (cfg_offset == off_ew_ratio);
	assign hit_ew_offsets = (cfg_offset == off_ew_offsets);
	assign hit_latency = (cfg_offset == off_read_latency);
	assign hit_page = (cfg_offset == off_page_close);
	assign hit_tx_ratios = (cfg_offset == off_tx_ratios);
	assign hit_cmd = (cfg_offset == off_tx_cmd_offsets);
	assign hit_data = (cfg_offset == off_tx_data_offsets);

	genvar g;
	generate
		for (g = 0; g < num_channels; g = g + 1) begin : chan
			logic sel;
			logic [2:0] ptr_sep_r;
			logic [7:0] rx_off_r, rx_far_r, rx_home_r;
			logic [7:0] ew_far_r, ew_even_r, ew_odd_r;
			logic [7:0] lat_r;
			logic [15:0] page_r;
			logic [7:0] tx_far_r, tx_home_r;
			logic [9:0] cmd_r;
			logic [16:0] data_r;
			logic [11:0] page_cnt_r;
			logic [11:0] page_cnt_nxt;
			logic [11:0] page_limit;
			logic flag_r;
			logic [7:0] sep_r;
			logic [7:0] sep_nxt;
			logic [7:0] rx_word_r;
			logic wr_rx;
			logic wr_ew_ratio;
			logic wr_ew_offsets;
			logic wr_latency;
			logic wr_page;
			logic wr_tx_ratios;
			logic wr_cmd;
			logic wr_data;
			logic [31:0] rd_word;
			logic [7:0] ew_far_out_r;
			logic [7:0] ew_even_out_r;
			logic [7:0] ew_odd_out_r;
			logic [7:0] tx_far_out_r;
			logic [7:0] tx_home_out_r;
			logic [1:0] cmd_ptr_r;
			logic [7:0] cmd_bg_r;
			logic [16:0] data_o_r;

			assign sel = cfg_wr && (cfg_chan == 2'(g));
			assign wr_rx = sel && hit_rx;
			assign wr_ew_ratio = sel && hit_ew_ratio;
			assign wr_ew_offsets = sel && hit_ew_offsets;
			assign wr_latency = sel && hit_latency;
			assign wr_page = sel && hit_page;
			assign wr_tx_ratios = sel && hit_tx_ratios;
			assign wr_cmd = sel && hit_cmd;
			assign wr_data = sel && hit_data;

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					ptr_sep_r <= rst_ptr_sep;
					rx_off_r <= rst_rx_offset;
					rx_far_r <= rst_rx_far;
					rx_home_r <= rst_rx_home;
				end else if (wr_rx) begin
					ptr_sep_r <= cfg_wdata[pos_ptr_sep +: 3];
					rx_off_r <= cfg_wdata[pos_offset +: 8];
					rx_far_r <= cfg_wdata[pos_far +: 8];
					rx_home_r <= cfg_wdata[pos_home +: 8];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					ew_far_r <= rst_ew_far;
				end else if (wr_ew_ratio) begin
					ew_far_r <= cfg_wdata[pos_far +: 8];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					ew_even_r <= rst_ew_even;
					ew_odd_r <= rst_ew_odd;
				end else if (wr_ew_offsets) begin
					ew_even_r <= cfg_wdata[pos_far +: 8];
					ew_odd_r <= cfg_wdata[pos_home +: 8];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					lat_r <= rst_latency;
				end else if (wr_latency) begin
					lat_r <= cfg_wdata[7:0];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					page_r <= rst_page_close;
				end else if (wr_page) begin
					page_r <= cfg_wdata[15:0];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					tx_far_r <= rst_tx_far;
					tx_home_r <= rst_tx_home;
				end else if (wr_tx_ratios) begin
					tx_far_r <= cfg_wdata[pos_far +: 8];
					tx_home_r <= cfg_wdata[pos_home +: 8];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					cmd_r <= rst_cmd_offsets;
				end else if (wr_cmd) begin
					cmd_r <= cfg_wdata[9:0];
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					data_r <= rst_data_offsets;
				end else if (wr_data) begin
					data_r <= cfg_wdata[16:0];
				end
			end

			// Readback selection; unmapped offsets read zero
			assign rd_word = hit_rx ?
				{5'h00, ptr_sep_r, rx_off_r, rx_far_r, rx_home_r} :
				hit_ew_ratio ? {16'h0000, ew_far_r, 8'h00} :
				hit_ew_offsets ? {16'h0000, ew_even_r, ew_odd_r} :
				hit_latency ? {24'h000000, lat_r} :
				hit_page ? {16'h0000, page_r} :
				hit_tx_ratios ? {16'h0000, tx_far_r, tx_home_r} :
				hit_cmd ? {22'h000000, cmd_r} :
				hit_data ? {15'h0000, data_r} : 32'h0000_0000;
			assign rd_mux[g] = rd_word;

			assign sep_nxt = lat_r;
			assign page_limit = {page_r[7:0], page_count_low_bits};
			assign page_cnt_nxt = (page_cnt_r >= page_limit) ?
				12'h000 : page_cnt_r + 12'h001;

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					page_cnt_r <= 12'h000;
					flag_r <= 1'b0;
					sep_r <= 8'h00;
					rx_word_r <= 8'h00;
				end else begin
					page_cnt_r <= page_cnt_nxt;
					flag_r <= (page_cnt_r >= page_limit);
					sep_r <= sep_nxt;
					rx_word_r <= rx_off_r;
				end
			end

			if (g == 0) begin : ch0
				assign cmd_bg0 = cmd_r[7:0];
				assign cmd_ptr0 = cmd_r[9:8];
			end

			// Output copies start at the reset values, so the crossing
			// logic never sees a zero ratio while the bank comes up
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					ew_far_out_r <= rst_ew_far;
					ew_even_out_r <= rst_ew_even;
					ew_odd_out_r <= rst_ew_odd;
					tx_far_out_r <= rst_tx_far;
					tx_home_out_r <= rst_tx_home;
				end else begin
					ew_far_out_r <= ew_far_r;
					ew_even_out_r <= ew_even_r;
					ew_odd_out_r <= ew_odd_r;
					tx_far_out_r <= tx_far_r;
					tx_home_out_r <= tx_home_r;
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					cmd_ptr_r <= rst_cmd_offsets[9:8];
					cmd_bg_r <= rst_cmd_offsets[7:0];
				end else begin
					cmd_ptr_r <= cmd_ptr0;
					cmd_bg_r <= cmd_bg0;
				end
			end

			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					data_o_r <= rst_data_offsets;
				end else begin
					data_o_r <= data_r;
				end
			end

			// Receive gearing carries the offset field only; the ratios
			// stay readable for software but are not exported
			assign rx_gearing[g*8 +: 8] = rx_word_r;
			assign rx_pointer_separation[g*8 +: 8] = sep_r;
			assign warning_far_ratio[g*8 +: 8] = ew_far_out_r;
			assign warning_even_phase_offset[g*8 +: 8] = ew_even_out_r;
			assign warning_odd_phase_offset[g*8 +: 8] = ew_odd_out_r;
			assign tx_far_ratio[g*8 +: 8] = tx_far_out_r;
			assign tx_home_ratio[g*8 +: 8] = tx_home_out_r;
			assign cmd_fifo_pointer_shift[g*2 +: 2] = cmd_ptr_r;
			assign cmd_bubble_gen_shift[g*8 +: 8] = cmd_bg_r;
			assign data_fifo_offsets[g*17 +: 17] = data_o_r;
			assign page_close_flag[g] = flag_r;
		end
	endgenerate
endmodule

// file: chan_xing_cfg_checker.sv
/*
 Port assertions for chan_xing_cfg.
 Assumes one ref_clk domain and the dword config port of the design.
*/
module chan_xing_cfg_checker
	import chan_xing_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [1:0] cfg_chan,
	input wire logic [7:0] cfg_offset,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid,
	input wire logic [23:0] rx_gearing,
	input wire logic [23:0] rx_pointer_separation,
	input wire logic [23:0] warning_far_ratio,
	input wire logic [5:0] cmd_fifo_pointer_shift,
	input wire logic [23:0] cmd_bubble_gen_shift
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic w0;
	assign w0 = cfg_wr && cfg_chan == 2'h0;
	property p_rd_answer;
		cfg_rd |=> cfg_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered next cycle");
	property p_chan3_zero;
		cfg_rd && cfg_chan == 2'h3 |=> cfg_rdata == 32'h0;
	endproperty
	a_chan3_zero: assert property (p_chan3_zero)
		else $error("channel 3 read not zero");
	property p_cmd_shared;
		cmd_bubble_gen_shift == {3{cmd_bubble_gen_shift[7:0]}};
	endproperty
	a_cmd_shared: assert property (p_cmd_shared)
		else $error("command bubble shift not shared");
	property p_cmd_ptr;
		cmd_fifo_pointer_shift == {3{cmd_fifo_pointer_shift[1:0]}};
	endproperty
	a_cmd_ptr: assert property (p_cmd_ptr)
		else $error("command pointer shift not shared");
	property p_lat;
		w0 && cfg_offset == 8'hD4 |=> ##1
			rx_pointer_separation[7:0] == $past(cfg_wdata[7:0], 2);
	endproperty
	a_lat: assert property (p_lat)
		else $error("separation does not follow latency");
	property p_rx_off;
		w0 && cfg_offset == 8'hC8 |=> ##1
			rx_gearing[7:0] == $past(cfg_wdata[23:16], 2);
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("rx offset not passed on");
	property p_sep_unused;
		cfg_wr && cfg_offset == 8'hC8 |=> ##1 $stable(rx_pointer_separation);
	endproperty
	a_sep_unused: assert property (p_sep_unused)
		else $error("separation field used by hardware");
	property p_ew_far;
		cfg_wr && cfg_chan == 2'h1 && cfg_offset == 8'hCC |=> ##1
			warning_far_ratio[15:8] == $past(cfg_wdata[15:8], 2);
	endproperty
	a_ew_far: assert property (p_ew_far)
		else $error("warning ratio not passed on");
endmodule

bind chan_xing_cfg chan_xing_cfg_checker chan_xing_cfg_checker_inst (.*);

// file: tb_top.sv
/*
 Self-checking bench for chan_xing_cfg: reset values, readback, refusals,
 derived outputs and page-close period. Assumes the bound checker.
*/
module tb_top;
	import chan_xing_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, arst_n = 0, cfg_wr = 0, cfg_rd = 0, cfg_rvalid;
	logic [1:0] cfg_chan = 0;
	logic [7:0] cfg_offset = 0;
	logic [31:0] cfg_wdata = 0, cfg_rdata;
	logic [23:0] rx_gearing, rx_pointer_separation, warning_far_ratio;
	logic [23:0] warning_even_phase_offset, warning_odd_phase_offset;
	logic [23:0] tx_far_ratio, tx_home_ratio, cmd_bubble_gen_shift;
	logic [5:0] cmd_fifo_pointer_shift;
	logic [50:0] data_fifo_offsets;
	logic [2:0] page_close_flag;
	logic [7:0] offs [9] = '{8'hC8, 8'hCC, 8'hD0, 8'hD4, 8'hD8, 8'hE0,
		8'hE4, 8'hE8, 8'hDC};
	logic [31:0] msk [8] = '{32'h07FFFFFF, 32'hFF00, 32'hFFFF, 32'hFF,
		32'hFFFF, 32'hFFFF, 32'h3FF, 32'h1FFFF};
	logic [31:0] rv [8] = '{32'h02000102, 32'h100, 32'h200, 0, 0,
		32'h104, 0, 0};
	logic [31:0] m [3][8];
	logic [31:0] q [$];
	int err_count = 0, n_checks = 0, seed = 44563, c, v, n;
	chan_xing_cfg chan_xing_cfg_inst (.*);
	always #2 ref_clk = ~ref_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic r, input int ch, input int i,
		input logic [31:0] dt);
		@(posedge ref_clk);
		cfg_wr <= w;
		cfg_rd <= r;
		cfg_chan <= ch[1:0];
		cfg_offset <= offs[i];
		cfg_wdata <= dt;
		if (r)
			q.push_back((ch > 2 || i > 7) ? 32'h0 : m[ch][i]);
		if (w && ch < 3 && i < 8)
			m[ch][i] = dt & msk[i];
	endtask
	task wt(output int cnt);
		cnt = 0;
		@(negedge ref_clk);
		while (page_close_flag[0] !== 1'b1 && cnt < 5000) begin
			cnt++;
			@(negedge ref_clk);
		end
	endtask
	task summarize;
		// A read that was never answered counts as a mismatch
		if (q.size() != 0)
			err_count++;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge ref_clk) begin
		if (cfg_rvalid === 1'b1)
			chk(cfg_rdata, q.pop_front());
	end
	initial begin
		// Whole run is a few hundred cycles; this allows 50000
		#200000;
		err_count++;
		summarize();
	end
	initial begin
		for (c = 0; c < 24; c++)
			m[c / 8][c % 8] = rv[c % 8];
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(tx_home_ratio, {3{rst_tx_home}});
		chk(warning_even_phase_offset, {3{rst_ew_even}});
		@(posedge ref_clk);
		arst_n <= 1;
		// Reset values, then random writes incl. channel 3 and a hole
		for (c = 0; c < 36; c++)
			acc(0, 1, c / 9, c % 9, 0);
		for (c = 0; c < 36; c++)
			acc(1, 0, c / 9, c % 9, $random(seed));
		for (c = 0; c < 36; c++)
			acc(0, 1, c / 9, c % 9, 0);
		acc(0, 0, 0, 0, 0);
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		for (c = 0; c < 3; c++) begin
			chk(rx_gearing[8*c+:8], m[c][0][23:16]);
			chk(warning_far_ratio[8*c+:8], m[c][1][15:8]);
			chk(warning_even_phase_offset[8*c+:8], m[c][2][15:8]);
			chk(warning_odd_phase_offset[8*c+:8], m[c][2][7:0]);
			chk(tx_far_ratio[8*c+:8], m[c][5][15:8]);
			chk(cmd_fifo_pointer_shift[2*c+:2], m[0][6][9:8]);
			chk(rx_pointer_separation[8*c+:8], m[c][3][7:0]);
			chk(cmd_bubble_gen_shift[8*c+:8], m[0][6][7:0]);
			chk(data_fifo_offsets[17*c+:17], m[c][7][16:0]);
			chk(tx_home_ratio[8*c+:8], m[c][5][7:0]);
		end
		// Page-close spacing: first gap may be stale, so measure the third
		for (v = 1; v < 3; v++) begin
			// upper byte set, period must not move
			acc(1, 0, 0, 4, 32'h5A00 | v);
			acc(0, 0, 0, 0, 0);
			wt(n);
			wt(n);
			wt(n);
			chk(n, 16 * v);
		end
		// Mid-run reset: every register returns to its reset value
		arst_n <= 0;
		@(posedge ref_clk);
		arst_n <= 1;
		for (c = 0; c < 24; c++)
			m[c / 8][c % 8] = rv[c % 8];
		for (c = 0; c < 27; c++)
			acc(0, 1, c / 9, c % 9, 0);
		acc(0, 0, 0, 0, 0);
		repeat (2) @(posedge ref_clk);
		summarize();
	end
endmodule
